// ===== hdl/fpec_pkg.sv
package fpec_pkg;

  // Register file addresses
  localparam logic [11:0] ADDR_CMD = 12'hFF8;
  localparam logic [11:0] ADDR_PAGE = 12'hFF9;
  localparam logic [11:0] ADDR_FREQ_HI = 12'hFFA;
  localparam logic [11:0] ADDR_FREQ_LO = 12'hFFB;

  // Command codes
  localparam logic [7:0] CMD_UNLOCK1 = 8'h73;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h8C;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;
  localparam logic [7:0] CMD_MASS_ERASE = 8'h63;
  localparam logic [7:0] CMD_SECTOR_SEL = 8'h5E;

  // Array constants
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int PAGE_LSB = 9;
  localparam int SECTOR_LSB = 10;
  localparam logic [8:0] PAGE_BASE_OFFSET = 9'h000;

  // Controller state codes
  localparam logic [5:0] ST_LOCKED = 6'h00;
  localparam logic [5:0] ST_FIRST = 6'h01;
  localparam logic [5:0] ST_SECOND = 6'h02;
  localparam logic [5:0] ST_UNLOCKED = 6'h03;
  localparam logic [5:0] ST_SECTOR = 6'h04;
  localparam logic [5:0] ST_PROG = 6'h08;
  localparam logic [5:0] ST_PERASE = 6'h10;
  localparam logic [5:0] ST_MERASE = 6'h20;

  // Values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_RATE = 16'h0000;

  // Timing: accumulator step, kHz per MHz
  localparam logic [16:0] KHZ_PER_MHZ = 17'h0_03E8;
  localparam int PROG_TIME_US = 40;
  localparam int PAGE_ERASE_TIME_US = 10000;
  localparam int MASS_ERASE_TIME_US = 200000;

  typedef enum logic [3:0] {
    FPEC_LOCKED,
    FPEC_FIRST,
    FPEC_SECOND,
    FPEC_UNLOCKED,
    FPEC_SECTOR,
    FPEC_PROG,
    FPEC_PERASE,
    FPEC_MERASE
  } fpec_state_t;

endpackage

// ===== hdl/fpec_op_timer.sv
`timescale 1ns/100ps
module fpec_op_timer
  import fpec_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic [19:0] duration_us,
  input wire logic [15:0] rate_khz,
  // Status
  output logic busy,
  output logic done
);

  logic [16:0] acc_reg;
  logic [16:0] acc_next;
  logic [19:0] left_reg;
  logic [19:0] left_next;
  logic run_reg;
  logic run_next;
  logic done_reg;
  logic done_next;
  logic [16:0] acc_sum;
  logic tick;

  //////////////////////////////////////////////////////////////////////////
  // Fractional microsecond prescaler: adds 1000 per cycle, wraps at kHz,
  // so odd clock rates keep their average without a divider
  always_comb begin
    acc_sum = acc_reg + KHZ_PER_MHZ;
    tick = run_reg && (acc_sum >= {1'b0, rate_khz});
    acc_next = acc_reg;
    left_next = left_reg;
    run_next = run_reg;
    done_next = 1'b0;
    if (start) begin
      acc_next = '0;
      // A zero duration still lasts one microsecond
      left_next = (duration_us == 20'h0_0000) ? 20'h0_0001 : duration_us;
      run_next = 1'b1;
    end else if (run_reg) begin
      acc_next = tick ? acc_sum - {1'b0, rate_khz} : acc_sum;
      if (tick) begin
        left_next = left_reg - 20'h0_0001;
        if (left_reg == 20'h0_0001) begin
          run_next = 1'b0;
          done_next = 1'b1;
        end
      end
    end
  end

  // Timer registers
  always_ff @(posedge clock) begin
    if (rst) begin
      acc_reg <= '0;
      left_reg <= '0;
      run_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      left_reg <= left_next;
      run_reg <= run_next;
      done_reg <= done_next;
    end
  end

  assign busy = run_reg;
  assign done = done_reg;

endmodule

// ===== hdl/fpec_controller.sv
`timescale 1ns/100ps
// Overview of operation
// [R1] Erased bytes read back as FFh
// [R2] Programming only clears bits, never sets
// [R3] Programming allowed only where erase/unlock opened
// [R4] Core stalled during operations, clock keeps running
// [R5] Non-erase command leaves programming mode, relocks
// [R6] Host programs each byte at most twice
// [R7] Page erase sets 512 bytes to FFh
// [R8] Page erase refused in protected sector
// [R9] Command 95h when unlocked starts page erase
// [R10] Page erase completion resumes core and relocks
// [R11] Mass erase 63h only via debugger, relocks
// [R12] Debugger polls status until operation done
// [R13] Bypass routes array controls to pins
// [R14] Debugger ignores write guard and sector guard
// [R15] Debugger programming not limited to page
// [R16] Debugger may clear sector guard bits
// [R17] Debugger skips page rewrite, may rewrite page
// [R18] Mass erase command needs debugger access
// [R19] One page per unlock sequence
// [R20] Unlock needs 73h then 8Ch
// [R21] Bad command or sequence relocks controller
// [R22] Command write and status read share FF8h
// [R23] Command 5Eh maps sector guard at page address
// [R24] Status field encodes controller state
// [R25] Page number forms address bits 15:9
// [R26] Page written twice, mismatch relocks
// [R27] Clock rate setting loaded in kHz first
// [R28] Stores outside open page are ignored
module fpec_controller
  import fpec_pkg::*;
#(
  parameter int PROG_US = PROG_TIME_US,
  parameter int PAGE_ERASE_US = PAGE_ERASE_TIME_US,
  parameter int MASS_ERASE_US = MASS_ERASE_TIME_US
)(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register file port
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Access mode and option
  input wire logic debug_access,
  input wire logic write_guard_option,
  // Program store from core or debugger
  input wire logic store_valid,
  input wire logic [15:0] store_addr,
  input wire logic [7:0] store_data,
  output logic cpu_stall,
  // Flash array
  input wire logic [7:0] flash_rdata,
  output logic [15:0] flash_addr,
  output logic [7:0] flash_wdata,
  output logic flash_prog,
  output logic flash_page_erase,
  output logic flash_mass_erase,
  // Bypass pins
  input wire logic bypass_en,
  input wire logic [15:0] bypass_addr,
  input wire logic [7:0] bypass_wdata,
  input wire logic bypass_prog,
  input wire logic bypass_page_erase
);

  import fpec_pkg::*;

  fpec_state_t state_reg;
  fpec_state_t state_next;
  logic [6:0] page_reg;
  logic [6:0] page_next;
  logic [7:0] info_reg;
  logic [7:0] info_next;
  logic [7:0] sector_guard_reg;
  logic [7:0] sector_guard_next;
  logic [15:0] rate_reg;
  logic [15:0] rate_next;
  logic [15:0] addr_reg;
  logic [15:0] addr_next;
  logic [7:0] data_reg;
  logic [7:0] data_next;
  logic [7:0] wdata_reg;
  logic [7:0] wdata_next;
  logic arm_reg;
  logic arm_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic timer_start;
  logic [19:0] timer_us;
  logic timer_busy;
  logic timer_done;
  logic cmd_wr;
  logic page_wr;
  logic guards_ok;
  logic store_ok;

  //////////////////////////////////////////////////////////////////////////
  // Status code of a state
  function automatic logic [5:0] state_code(input fpec_state_t s);
    case (s)
      FPEC_FIRST: state_code = ST_FIRST;
      FPEC_SECOND: state_code = ST_SECOND;
      FPEC_UNLOCKED: state_code = ST_UNLOCKED;
      FPEC_SECTOR: state_code = ST_SECTOR;
      FPEC_PROG: state_code = ST_PROG;
      FPEC_PERASE: state_code = ST_PERASE;
      FPEC_MERASE: state_code = ST_MERASE;
      default: state_code = ST_LOCKED;
    endcase
  endfunction

  // Sector guard bit covering an address
  function automatic logic guarded(input logic [7:0] g,
                                   input logic [15:0] a);
    guarded = g[a[SECTOR_LSB+2:SECTOR_LSB]];
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Strobes and permission terms
  assign cmd_wr = reg_wr && (reg_addr == ADDR_CMD); // [R22]
  assign page_wr = reg_wr && (reg_addr == ADDR_PAGE);
  // Debugger bypasses write guard option and sector guard
  assign guards_ok = debug_access ||
    (write_guard_option &&
     !guarded(sector_guard_reg, {page_reg, PAGE_BASE_OFFSET})); // [R8] [R14]
  // Store target check; debugger may program anywhere
  assign store_ok = debug_access ||
    (write_guard_option &&
     store_addr[15:PAGE_LSB] == page_reg &&
     !guarded(sector_guard_reg, store_addr)); // [R3] [R15] [R28]

  //////////////////////////////////////////////////////////////////////////
  // Controller sequence and register writes
  always_comb begin
    state_next = state_reg;
    page_next = page_reg;
    info_next = info_reg;
    sector_guard_next = sector_guard_reg;
    rate_next = rate_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    wdata_next = wdata_reg;
    arm_next = 1'b0;
    timer_start = 1'b0;
    timer_us = 20'(PROG_US);
    // Rate setting is plain storage; loading it is software's job
    if (reg_wr && reg_addr == ADDR_FREQ_HI) begin
      rate_next = {reg_wdata, rate_reg[7:0]}; // [R27]
    end else if (reg_wr && reg_addr == ADDR_FREQ_LO) begin
      rate_next = {rate_reg[15:8], reg_wdata}; // [R27]
    end
    case (state_reg)
      FPEC_LOCKED: begin
        if (page_wr) begin
          page_next = reg_wdata[6:0]; // [R25]
          info_next = {reg_wdata[7], 7'h00};
        end
        if (cmd_wr && reg_wdata == CMD_UNLOCK1) begin
          state_next = FPEC_FIRST; // [R20]
        end else if (cmd_wr && reg_wdata == CMD_SECTOR_SEL) begin
          state_next = FPEC_SECTOR; // [R23]
        end
      end
      FPEC_FIRST: begin
        if (cmd_wr && reg_wdata == CMD_UNLOCK2) begin
          // Debugger needs no page rewrite
          state_next = debug_access ? FPEC_UNLOCKED : FPEC_SECOND; // [R17]
        end else if (reg_wr) begin
          state_next = FPEC_LOCKED; // [R20] [R21]
        end
      end
      FPEC_SECOND: begin
        if (page_wr && reg_wdata[6:0] == page_reg) begin
          state_next = FPEC_UNLOCKED; // [R26]
        end else if (reg_wr) begin
          state_next = FPEC_LOCKED; // [R21] [R26]
        end
      end
      FPEC_UNLOCKED: begin
        if (cmd_wr) begin
          if (reg_wdata == CMD_PAGE_ERASE && guards_ok) begin
            state_next = FPEC_PERASE; // [R9]
            timer_start = 1'b1;
            timer_us = 20'(PAGE_ERASE_US);
            addr_next = {page_reg, PAGE_BASE_OFFSET}; // [R25]
            wdata_next = ERASED_BYTE; // [R7]
          end else if (reg_wdata == CMD_MASS_ERASE && debug_access) begin
            state_next = FPEC_MERASE; // [R11] [R18]
            timer_start = 1'b1;
            timer_us = 20'(MASS_ERASE_US);
            addr_next = 16'h0000;
            wdata_next = ERASED_BYTE; // [R1]
          end else begin
            state_next = FPEC_LOCKED; // [R5] [R19] [R21]
          end
        end else if (page_wr && debug_access) begin
          page_next = reg_wdata[6:0]; // [R17]
        end else if (store_valid && store_ok) begin
          state_next = FPEC_PROG;
          arm_next = 1'b1;
          addr_next = store_addr;
          data_next = store_data;
        end
      end
      FPEC_SECTOR: begin
        if (page_wr) begin
          // Core may only set bits; debugger may set or clear
          sector_guard_next = debug_access ? reg_wdata :
            (sector_guard_reg | reg_wdata); // [R16] [R23]
        end else if (cmd_wr && reg_wdata != CMD_SECTOR_SEL) begin
          state_next = (reg_wdata == CMD_UNLOCK1) ?
            FPEC_FIRST : FPEC_LOCKED; // [R21]
        end
      end
      FPEC_PROG: begin
        if (arm_reg) begin
          // Merge with stored byte: ones cannot be restored
          wdata_next = data_reg & flash_rdata; // [R2]
          timer_start = 1'b1;
          timer_us = 20'(PROG_US);
        end else if (timer_done) begin
          state_next = FPEC_UNLOCKED; // [R19]
        end
      end
      FPEC_PERASE: begin
        if (timer_done) begin
          state_next = FPEC_LOCKED; // [R10]
        end
      end
      FPEC_MERASE: begin
        if (timer_done) begin
          state_next = FPEC_LOCKED; // [R11]
        end
      end
      default: state_next = FPEC_LOCKED;
    endcase
  end

  // Sequence registers
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= FPEC_LOCKED;
      page_reg <= '0;
      info_reg <= RST_BYTE;
      sector_guard_reg <= RST_BYTE;
      rate_reg <= RST_RATE;
      addr_reg <= '0;
      data_reg <= ERASED_BYTE;
      wdata_reg <= ERASED_BYTE;
      arm_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      page_reg <= page_next;
      info_reg <= info_next;
      sector_guard_reg <= sector_guard_next;
      rate_reg <= rate_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      wdata_reg <= wdata_next;
      arm_reg <= arm_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Operation timer, scaled by the clock rate setting
  fpec_op_timer u_timer (
    .clock(clock),
    .rst(rst),
    .start(timer_start),
    .duration_us(timer_us),
    .rate_khz(rate_reg),
    .busy(timer_busy),
    .done(timer_done)
  );

  //////////////////////////////////////////////////////////////////////////
  // Register read data, one cycle after the read strobe
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd) begin
      if (reg_addr == ADDR_CMD) begin
        rdata_next = {2'b00, state_code(state_reg)}; // [R22] [R24] [R12]
      end else if (reg_addr == ADDR_PAGE) begin
        rdata_next = (state_reg == FPEC_SECTOR) ? sector_guard_reg :
          (info_reg | {1'b0, page_reg});
      end else if (reg_addr == ADDR_FREQ_HI) begin
        rdata_next = rate_reg[15:8];
      end else if (reg_addr == ADDR_FREQ_LO) begin
        rdata_next = rate_reg[7:0];
      end else begin
        rdata_next = RST_BYTE;
      end
    end
  end

  // Read data register
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_reg <= RST_BYTE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  //////////////////////////////////////////////////////////////////////////
  // Core stall while any controller array operation runs (pin bypass operations do not stall); clock is never gated
  assign cpu_stall = (state_reg == FPEC_PROG) ||
    (state_reg == FPEC_PERASE) || (state_reg == FPEC_MERASE); // [R4]

  // Array controls, or pins when bypassed; mass erase is held off when bypassed
  assign flash_addr = bypass_en ? bypass_addr : addr_reg; // [R13]
  assign flash_wdata = bypass_en ? bypass_wdata : wdata_reg; // [R13]
  assign flash_prog = bypass_en ? bypass_prog :
    (state_reg == FPEC_PROG && timer_busy); // [R13]
  assign flash_page_erase = bypass_en ? bypass_page_erase :
    (state_reg == FPEC_PERASE && timer_busy); // [R13] [R7]
  assign flash_mass_erase = !bypass_en &&
    (state_reg == FPEC_MERASE && timer_busy); // [R11]

endmodule

// ===== tb/fpec_controller_sva.sv
`timescale 1ns/100ps
module fpec_controller_sva (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Modes and stores
  input wire logic debug_access,
  input wire logic write_guard_option,
  input wire logic store_valid,
  input wire logic cpu_stall,
  // Flash array and bypass pins
  input wire logic [7:0] flash_rdata,
  input wire logic [15:0] flash_addr,
  input wire logic [7:0] flash_wdata,
  input wire logic flash_prog,
  input wire logic flash_page_erase,
  input wire logic flash_mass_erase,
  input wire logic bypass_en,
  input wire logic [15:0] bypass_addr
);
  import fpec_pkg::*;

  // One domain, so clock and reset are given once
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  property p_prg;
    flash_prog && !bypass_en |-> cpu_stall;
  endproperty
  a_prg: assert property (p_prg) else $error("prog without stall");
  property p_ers;
    (flash_page_erase || flash_mass_erase) && !bypass_en |-> cpu_stall;
  endproperty
  a_ers: assert property (p_ers) else $error("erase without stall");
  // A set bit in the write data over a cleared cell would raise it
  property p_mrg;
    flash_prog && !bypass_en |-> (flash_wdata & ~flash_rdata) == 8'h00;
  endproperty
  a_mrg: assert property (p_mrg) else $error("prog sets a bit");
  property p_pge;
    flash_page_erase && !bypass_en |->
      flash_addr[8:0] == PAGE_BASE_OFFSET && flash_wdata == ERASED_BYTE;
  endproperty
  a_pge: assert property (p_pge) else $error("erase addr or data");
  property p_mdb;
    $rose(flash_mass_erase) && !bypass_en |-> $past(debug_access);
  endproperty
  a_mdb: assert property (p_mdb) else $error("mass erase by core");
  property p_sts;
    reg_rd && reg_addr == ADDR_CMD && flash_mass_erase && !bypass_en
      |=> reg_rdata == {2'b00, ST_MERASE};
  endproperty
  a_sts: assert property (p_sts) else $error("status code");
  property p_wgo;
    store_valid && !write_guard_option && !debug_access && !cpu_stall
      |=> !cpu_stall [*2];
  endproperty
  a_wgo: assert property (p_wgo) else $error("guarded store ran");
  property p_end;
    $fell(cpu_stall) && !bypass_en |->
      !flash_prog && !flash_page_erase && !flash_mass_erase;
  endproperty
  a_end: assert property (p_end) else $error("resume mid op");
  property p_len;
    $rose(flash_page_erase) && !bypass_en |-> ##[1:200] !flash_page_erase;
  endproperty
  a_len: assert property (p_len) else $error("erase never ends");
  property p_byp;
    bypass_en |-> flash_addr == bypass_addr;
  endproperty
  a_byp: assert property (p_byp) else $error("bypass addr");
endmodule

// ===== tb/fpec_flash_model.sv
`timescale 1ns/100ps
module fpec_flash_model (
  // Clock
  input wire logic clock,
  // Array controls
  input wire logic [15:0] flash_addr,
  input wire logic [7:0] flash_wdata,
  input wire logic flash_prog,
  input wire logic flash_page_erase,
  input wire logic flash_mass_erase,
  // Array read
  output logic [7:0] flash_rdata
);
  logic [7:0] mem [0:8191];
  logic erase_prev;

  // Preload a pattern so that erases and merges show
  initial begin
    for (int i = 0; i < 8192; i++) begin
      mem[i] = 8'h5A;
    end
    erase_prev = 1'b0;
  end
  // Programming only clears ones; an erase acts once on its rising request
  always @(posedge clock) begin
    erase_prev <= flash_page_erase | flash_mass_erase;
    if (flash_prog) begin
      mem[flash_addr[12:0]] <= mem[flash_addr[12:0]] & flash_wdata;
    end
    if (flash_page_erase && !erase_prev) begin
      for (int i = 0; i < 512; i++) begin
        mem[{flash_addr[12:9], i[8:0]}] <= 8'hFF;
      end
    end
    if (flash_mass_erase && !erase_prev) begin
      for (int i = 0; i < 8192; i++) begin
        mem[i] <= 8'hFF;
      end
    end
  end
  assign flash_rdata = mem[flash_addr[12:0]];
endmodule

// ===== tb/test_flash_program_erase_controller.sv
`timescale 1ns/100ps
module test_flash_program_erase_controller;
  import fpec_pkg::*;
  logic clock, rst, reg_wr, reg_rd, debug_access, write_guard_option;
  logic store_valid, cpu_stall, flash_prog, flash_page_erase;
  logic flash_mass_erase, bypass_en, bypass_prog, bypass_perase;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, store_data, flash_rdata, flash_wdata, rv;
  logic [7:0] bypass_wdata;
  logic [15:0] store_addr, flash_addr, bypass_addr;
  int err_total, checks;
  bit s;

  // Short op times keep the run brief
  fpec_controller #(.PROG_US(2), .PAGE_ERASE_US(4), .MASS_ERASE_US(6)) dut (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .debug_access(debug_access), .write_guard_option(write_guard_option),
    .store_valid(store_valid), .store_addr(store_addr),
    .store_data(store_data), .cpu_stall(cpu_stall),
    .flash_rdata(flash_rdata), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .flash_prog(flash_prog),
    .flash_page_erase(flash_page_erase),
    .flash_mass_erase(flash_mass_erase), .bypass_en(bypass_en),
    .bypass_addr(bypass_addr), .bypass_wdata(bypass_wdata),
    .bypass_prog(bypass_prog), .bypass_page_erase(bypass_perase));
  fpec_flash_model far (
    .clock(clock), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_prog(flash_prog), .flash_page_erase(flash_page_erase),
    .flash_mass_erase(flash_mass_erase), .flash_rdata(flash_rdata));

  // Compare and count
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Register write, one-cycle strobe launched at a falling edge
  task automatic wr(logic [11:0] a, logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask
  // Register read; data lands after the sampling edge
  task automatic rd(logic [11:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    d = reg_rdata;
    reg_rd = 1'b0;
  endtask
  task automatic stat(logic [7:0] e);
    rd(ADDR_CMD, rv);
    check("status", e, rv);
  endtask
  // Bounded wait for a stall to come and go; gives up early if none
  task automatic wait_op(output bit seen);
    seen = 0;
    for (int n = 0; n < 300; n++) begin
      if (cpu_stall === 1'b1) seen = 1;
      if (seen ? cpu_stall === 1'b0 : n > 8) break;
      @(negedge clock);
    end
  endtask
  task automatic store(logic [15:0] a, logic [7:0] d, output bit seen);
    @(negedge clock);
    store_addr = a;
    store_data = d;
    store_valid = 1'b1;
    @(negedge clock);
    store_valid = 1'b0;
    wait_op(seen);
  endtask
  task automatic unlock(logic [7:0] p);
    wr(ADDR_PAGE, p);
    wr(ADDR_CMD, CMD_UNLOCK1);
    wr(ADDR_CMD, CMD_UNLOCK2);
    wr(ADDR_PAGE, p);
  endtask
  task automatic t_page;
    wr(ADDR_FREQ_HI, 8'h00);
    wr(ADDR_FREQ_LO, 8'hFA);
    rd(ADDR_FREQ_LO, rv);
    check("rate lo", 8'hFA, rv);
    wr(ADDR_PAGE, 8'h02);
    wr(ADDR_CMD, CMD_UNLOCK1);
    stat(ST_FIRST);
    wr(ADDR_CMD, CMD_UNLOCK2);
    stat(ST_SECOND);
    wr(ADDR_PAGE, 8'h02);
    stat(ST_UNLOCKED);
    store(16'h0405, 8'h0F, s);
    check("prog stall", 1, s);
    check("prog byte", 8'h0A, far.mem[13'h0405]);
    store(16'h0600, 8'h00, s);
    check("off page", 8'h5A, far.mem[13'h0600]);
    wr(ADDR_CMD, CMD_PAGE_ERASE);
    wait_op(s);
    check("erase stall", 1, s);
    check("erase lo", 8'hFF, far.mem[13'h0405]);
    check("erase hi", 8'hFF, far.mem[13'h05FF]);
    check("next page", 8'h5A, far.mem[13'h0600]);
    stat(ST_LOCKED);
    // Locked again, so a store must leave the erased byte alone
    store(16'h0405, 8'h00, s);
    check("locked stall", 0, s);
    check("locked store", 8'hFF, far.mem[13'h0405]);
  endtask
  task automatic t_bad;
    wr(ADDR_PAGE, 8'h03);
    wr(ADDR_CMD, CMD_UNLOCK1);
    wr(ADDR_CMD, CMD_UNLOCK2);
    wr(ADDR_PAGE, 8'h04);
    stat(ST_LOCKED);
    wr(ADDR_CMD, CMD_UNLOCK1);
    wr(ADDR_CMD, 8'h00);
    stat(ST_LOCKED);
    unlock(8'h03);
    wr(ADDR_CMD, 8'h11);
    stat(ST_LOCKED);
    unlock(8'h01);
    write_guard_option = 1'b0;
    store(16'h0200, 8'h00, s);
    check("guarded store", 0, s);
    write_guard_option = 1'b1;
    wr(ADDR_CMD, CMD_MASS_ERASE);
    wait_op(s);
    check("core mass", 0, s);
    stat(ST_LOCKED);
  endtask
  task automatic t_sector;
    wr(ADDR_CMD, CMD_SECTOR_SEL);
    stat(ST_SECTOR);
    wr(ADDR_PAGE, 8'h01);
    wr(ADDR_PAGE, 8'h00);
    rd(ADDR_PAGE, rv);
    check("guard set only", 8'h01, rv);
    wr(ADDR_CMD, 8'h00);
    unlock(8'h00);
    wr(ADDR_CMD, CMD_PAGE_ERASE);
    wait_op(s);
    check("guarded erase", 0, s);
    check("guarded byte", 8'h5A, far.mem[13'h0000]);
    wr(ADDR_CMD, 8'h00);
  endtask
  // Debugger: relaxed unlock, any page, mass erase polled
  task automatic t_debug;
    debug_access = 1'b1;
    write_guard_option = 1'b0;
    wr(ADDR_CMD, CMD_SECTOR_SEL);
    wr(ADDR_PAGE, 8'h00);
    rd(ADDR_PAGE, rv);
    check("guard clear", 8'h00, rv);
    wr(ADDR_CMD, 8'h00);
    wr(ADDR_CMD, CMD_UNLOCK1);
    wr(ADDR_CMD, CMD_UNLOCK2);
    stat(ST_UNLOCKED);
    store(16'h1100, 8'h33, s);
    check("any page", 8'h12, far.mem[13'h1100]);
    wr(ADDR_CMD, CMD_MASS_ERASE);
    rv = ST_MERASE;
    for (int n = 0; n < 300 && rv !== ST_LOCKED; n++) begin
      rd(ADDR_CMD, rv);
    end
    check("mass byte", 8'hFF, far.mem[13'h1100]);
    check("mass relock", ST_LOCKED, rv);
    debug_access = 1'b0;
    write_guard_option = 1'b1;
  endtask
  task automatic t_bypass;
    bypass_addr = 16'h0123;
    bypass_en = 1'b1;
    @(negedge clock);
    check("bypass addr", 16'h0123, flash_addr);
    bypass_wdata = 8'h3C;
    bypass_prog = 1'b1;
    @(negedge clock);
    bypass_prog = 1'b0;
    @(negedge clock);
    check("bypass prog", 8'h3C, far.mem[13'h0123]);
    // Page erase straight from the pins restores the byte
    bypass_perase = 1'b1;
    @(negedge clock);
    bypass_perase = 1'b0;
    @(negedge clock);
    bypass_en = 1'b0;
    check("bypass erase", 8'hFF, far.mem[13'h0123]);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Whole sequence needs a few hundred cycles; cut off far beyond that
  initial begin
    #200000;
    err_total++;
    $display("ERROR watchdog expected done seen hang");
    complete_run();
  end
  initial begin
    {rst, reg_wr, reg_rd, store_valid, bypass_en, bypass_prog} = 6'b100000;
    bypass_perase = 1'b0;
    {debug_access, write_guard_option} = 2'b01;
    {reg_addr, reg_wdata, store_data, bypass_wdata} = 36'h0;
    {store_addr, bypass_addr} = 32'h0;
    repeat (16) @(negedge clock);
    rst = 1'b0;
    stat(ST_LOCKED);
    rd(12'hFFC, rv);
    check("unmapped", 8'h00, rv);
    t_page();
    t_bad();
    t_sector();
    t_debug();
    t_bypass();
    complete_run();
  end
endmodule

bind fpec_controller fpec_controller_sva chk (
  .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .debug_access(debug_access),
  .write_guard_option(write_guard_option), .store_valid(store_valid),
  .cpu_stall(cpu_stall), .flash_rdata(flash_rdata),
  .flash_addr(flash_addr), .flash_wdata(flash_wdata),
  .flash_prog(flash_prog), .flash_page_erase(flash_page_erase),
  .flash_mass_erase(flash_mass_erase), .bypass_en(bypass_en),
  .bypass_addr(bypass_addr));
